/* File: src/serdes_regs_pkg.sv */
// Shared constants for the link status and converter control register group.
// Assumes an 8-bit register port with a 10-bit register address.
package serdes_regs_pkg;

  // ****************************************************************
  // Widths and counts
  // ****************************************************************
  localparam int ADDR_W     = 10;
  localparam int DATA_W     = 8;
  localparam int LANES      = 16;
  localparam int LANE_SEL_W = 4;
  localparam int SYNTHS     = 4;
  localparam int PHASE_W    = 8;
  localparam int ARR_W      = 8;
  localparam int OFS_W      = 16;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] PHASE_STATUS_OFS  = 10'h239;
  localparam logic [ADDR_W-1:0] SYNTH_STATUS_OFS  = 10'h250;
  localparam logic [ADDR_W-1:0] LINK_RESET_OFS    = 10'h253;
  localparam logic [ADDR_W-1:0] EXT_REF_OFS       = 10'h2b0;
  localparam logic [ADDR_W-1:0] CUR_DOUBLE_OFS    = 10'h2b1;
  localparam logic [ADDR_W-1:0] OFFSET_BLOCK_OFS  = 10'h2cf;
  localparam logic [ADDR_W-1:0] DATAPATH_EN_OFS   = 10'h2e0;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int LOCK_LIVE_LSB = 4;
  localparam int LOSS_LSB      = 0;
  localparam int CTRL_BIT      = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] LINK_RESET_RST   = 8'h00;
  localparam logic [DATA_W-1:0] EXT_REF_RST      = 8'h00;
  localparam logic [DATA_W-1:0] CUR_DOUBLE_RST   = 8'h00;
  localparam logic [DATA_W-1:0] OFFSET_BLOCK_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATAPATH_EN_RST  = 8'h00;
  localparam logic [SYNTHS-1:0] LOSS_RST         = 4'h0;
  localparam logic [SYNTHS-1:0] LOCK_SYNC_RST    = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_RST        = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_RDATA   = 8'h00;
  localparam logic [OFS_W-1:0]  OFFSET_RST       = 16'h0000;
  localparam logic [ARR_W-1:0]  ARRIVAL_RST      = 8'h00;

endpackage

/* File: src/offset_if.sv */
// Interface between the register group and the converter offset release stage.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ps
interface offset_if;
  logic                               hold;
  logic [serdes_regs_pkg::OFS_W-1:0]  pending_a;
  logic [serdes_regs_pkg::OFS_W-1:0]  pending_b;
  logic [serdes_regs_pkg::OFS_W-1:0]  applied_a;
  logic [serdes_regs_pkg::OFS_W-1:0]  applied_b;

  modport ctrl  (output hold, output pending_a, output pending_b,
                 input applied_a, input applied_b);
  modport apply (input hold, input pending_a, input pending_b,
                 output applied_a, output applied_b);
endinterface

/* File: src/offset_release.sv */
// Holds the offsets used by both converters and releases pending values together.
// Assumes pending offsets come from registers on the same clock.
`timescale 1ns/1ps
module offset_release (
  input  wire logic   sys_clk,
  input  wire logic   reset_n,
  offset_if.apply     ofs
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [serdes_regs_pkg::OFS_W-1:0] applied_a;
    logic [serdes_regs_pkg::OFS_W-1:0] applied_b;
  } rel_state_t;

  rel_state_t rel_ff;
  rel_state_t nxt_rel;

  // Both offsets load from one enable, so a release can never split across cycles.
  always_comb begin
    nxt_rel = rel_ff;
    if (!ofs.hold) begin // see (R13) (R14)
      nxt_rel.applied_a = ofs.pending_a;
      nxt_rel.applied_b = ofs.pending_b;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rel_ff <= '{applied_a: serdes_regs_pkg::OFFSET_RST, applied_b: serdes_regs_pkg::OFFSET_RST};
    end else begin
      rel_ff <= nxt_rel;
    end
  end

  assign ofs.applied_a = rel_ff.applied_a;
  assign ofs.applied_b = rel_ff.applied_b;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking rel_cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  offset_held_a: assert property (ofs.hold |=> $stable(ofs.applied_a) && $stable(ofs.applied_b)) // see (R13)
    else $error("Offsets changed while held.");
  offset_release_a: assert property ($fell(ofs.hold) |=> // see (R14)
      ofs.applied_a == $past(ofs.pending_a) && ofs.applied_b == $past(ofs.pending_b))
    else $error("Offsets not released together.");
  offset_release_c: cover property ($fell(ofs.hold) ##1 $changed(ofs.applied_a));

endmodule

/* File: src/serdes_status_dac_ctrl_regs.sv */
// Link status and converter control register group on the configuration port.
// Assumes phase, lane select, arrival and offset inputs come from same-clock logic;
// the synthesizer lock inputs are asynchronous and are synchronised here.
//
// What this block does
// (R1) Phase register returns selected lane phase.
// (R2) Phase value is presented Gray coded.
// (R3) Software may freeze recovery before reading phase.
// (R4) Status bits 7-4 show live synthesizer lock.
// (R5) Loss bit sets whenever its lock is low.
// (R6) Loss bits map to groups of four lanes.
// (R7) Loss bits sticky; write one clears them.
// (R8) Link hold keeps digital link logic reset.
// (R9) Software holds link before enable, releases later.
// (R10) Arrival values captured on first release only.
// (R11) Reference select picks the external voltage reference.
// (R12) Current double bit doubles output current.
// (R13) Offset hold blocks offset updates to converters.
// (R14) Hold release applies both offsets together.
// (R15) Datapath run bit releases datapath reset.
// (R16) Reserved control bits store and read back.
`timescale 1ns/1ps
module serdes_status_dac_ctrl_regs (
  input  wire logic                                               sys_clk,
  input  wire logic                                               reset_n,
  input  wire logic [serdes_regs_pkg::ADDR_W-1:0]                 cfg_addr,
  input  wire logic                                               cfg_wr_en,
  input  wire logic                                               cfg_rd_en,
  input  wire logic [serdes_regs_pkg::DATA_W-1:0]                 cfg_wdata,
  output logic      [serdes_regs_pkg::DATA_W-1:0]                 cfg_rdata,
  input  wire logic [serdes_regs_pkg::LANE_SEL_W-1:0]             lane_select,
  input  wire logic [serdes_regs_pkg::LANES*serdes_regs_pkg::PHASE_W-1:0] lane_phase_bin,
  input  wire logic [serdes_regs_pkg::SYNTHS-1:0]                 synth_lock_live,
  input  wire logic                                               eb_release_attempt,
  input  wire logic [serdes_regs_pkg::LANES*serdes_regs_pkg::ARR_W-1:0] lane_arrival_in,
  output logic      [serdes_regs_pkg::LANES*serdes_regs_pkg::ARR_W-1:0] lane_arrival_capture,
  output logic                                                    link_reset_n,
  output logic                                                    external_vref_select,
  output logic                                                    output_current_double,
  output logic                                                    datapath_reset_n,
  input  wire logic [serdes_regs_pkg::OFS_W-1:0]                  offset_pending_a,
  input  wire logic [serdes_regs_pkg::OFS_W-1:0]                  offset_pending_b,
  output logic      [serdes_regs_pkg::OFS_W-1:0]                  offset_applied_a,
  output logic      [serdes_regs_pkg::OFS_W-1:0]                  offset_applied_b
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [serdes_regs_pkg::SYNTHS-1:0]                       lock_meta;
    logic [serdes_regs_pkg::SYNTHS-1:0]                       lock_sync;
    logic [serdes_regs_pkg::SYNTHS-1:0]                       loss_sticky;
    logic [serdes_regs_pkg::DATA_W-1:0]                       link_reset;
    logic [serdes_regs_pkg::DATA_W-1:0]                       ext_ref;
    logic [serdes_regs_pkg::DATA_W-1:0]                       cur_double;
    logic [serdes_regs_pkg::DATA_W-1:0]                       offset_block;
    logic [serdes_regs_pkg::DATA_W-1:0]                       datapath_en;
    logic [serdes_regs_pkg::DATA_W-1:0]                       rdata;
    logic                                                     arrival_done;
    logic [serdes_regs_pkg::LANES*serdes_regs_pkg::ARR_W-1:0] arrival;
  } reg_state_t;

  localparam reg_state_t STATE_RST = '{
    lock_meta:    serdes_regs_pkg::LOCK_SYNC_RST,
    lock_sync:    serdes_regs_pkg::LOCK_SYNC_RST,
    loss_sticky:  serdes_regs_pkg::LOSS_RST,
    link_reset:   serdes_regs_pkg::LINK_RESET_RST,
    ext_ref:      serdes_regs_pkg::EXT_REF_RST,
    cur_double:   serdes_regs_pkg::CUR_DOUBLE_RST,
    offset_block: serdes_regs_pkg::OFFSET_BLOCK_RST,
    datapath_en:  serdes_regs_pkg::DATAPATH_EN_RST,
    rdata:        serdes_regs_pkg::RDATA_RST,
    arrival_done: 1'b0,
    arrival:      {serdes_regs_pkg::LANES{serdes_regs_pkg::ARRIVAL_RST}}
  };

  reg_state_t                           st_ff;
  reg_state_t                           nxt_st;
  logic [serdes_regs_pkg::PHASE_W-1:0]  phase_bin_sel;
  logic [serdes_regs_pkg::PHASE_W-1:0]  phase_gray;
  logic [serdes_regs_pkg::SYNTHS-1:0]   loss_clear;
  logic                                 wr_status;

  // ****************************************************************
  // Phase selection
  // ****************************************************************
  // Gray coding is done on the selected word only, so a read during tracking sees
  // at most one changing bit instead of a torn binary value.
  always_comb begin
    phase_bin_sel = lane_phase_bin[lane_select*serdes_regs_pkg::PHASE_W +: // see (R1)
                                   serdes_regs_pkg::PHASE_W];
    phase_gray    = phase_bin_sel ^ (phase_bin_sel >> 1); // see (R2)
  end

  assign wr_status  = cfg_wr_en && (cfg_addr == serdes_regs_pkg::SYNTH_STATUS_OFS);
  assign loss_clear = wr_status ? cfg_wdata[serdes_regs_pkg::LOSS_LSB +: serdes_regs_pkg::SYNTHS]
                                : serdes_regs_pkg::LOSS_RST;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    // Lock inputs come from the synthesizer macros on their own timing.
    nxt_st.lock_meta = synth_lock_live;
    nxt_st.lock_sync = st_ff.lock_meta;
    // A lock drop in the clearing cycle keeps the bit set.
    nxt_st.loss_sticky = (st_ff.loss_sticky & ~loss_clear) | ~st_ff.lock_sync; // see (R5) (R6) (R7)

    if (cfg_wr_en) begin
      case (cfg_addr)
        serdes_regs_pkg::LINK_RESET_OFS:   nxt_st.link_reset   = cfg_wdata; // see (R16)
        serdes_regs_pkg::EXT_REF_OFS:      nxt_st.ext_ref      = cfg_wdata;
        serdes_regs_pkg::CUR_DOUBLE_OFS:   nxt_st.cur_double   = cfg_wdata;
        serdes_regs_pkg::OFFSET_BLOCK_OFS: nxt_st.offset_block = cfg_wdata;
        serdes_regs_pkg::DATAPATH_EN_OFS:  nxt_st.datapath_en  = cfg_wdata;
        default: begin
        end
      endcase
    end

    if (cfg_rd_en) begin
      case (cfg_addr)
        serdes_regs_pkg::PHASE_STATUS_OFS: nxt_st.rdata = phase_gray; // see (R1) (R2)
        serdes_regs_pkg::SYNTH_STATUS_OFS: nxt_st.rdata = {st_ff.lock_sync, st_ff.loss_sticky}; // see (R4)
        serdes_regs_pkg::LINK_RESET_OFS:   nxt_st.rdata = st_ff.link_reset;
        serdes_regs_pkg::EXT_REF_OFS:      nxt_st.rdata = st_ff.ext_ref;
        serdes_regs_pkg::CUR_DOUBLE_OFS:   nxt_st.rdata = st_ff.cur_double;
        serdes_regs_pkg::OFFSET_BLOCK_OFS: nxt_st.rdata = st_ff.offset_block;
        serdes_regs_pkg::DATAPATH_EN_OFS:  nxt_st.rdata = st_ff.datapath_en;
        default:                           nxt_st.rdata = serdes_regs_pkg::UNMAPPED_RDATA;
      endcase
    end

    // Holding the link digital logic re-arms the one-shot arrival capture.
    if (st_ff.link_reset[serdes_regs_pkg::CTRL_BIT]) begin // see (R8)
      nxt_st.arrival_done = 1'b0;
    end else if (eb_release_attempt && !st_ff.arrival_done) begin // see (R10)
      nxt_st.arrival_done = 1'b1;
      nxt_st.arrival      = lane_arrival_in;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cfg_rdata             = st_ff.rdata;
  assign lane_arrival_capture  = st_ff.arrival;
  assign link_reset_n          = ~st_ff.link_reset[serdes_regs_pkg::CTRL_BIT]; // see (R8)
  assign external_vref_select  = st_ff.ext_ref[serdes_regs_pkg::CTRL_BIT]; // see (R11)
  assign output_current_double = st_ff.cur_double[serdes_regs_pkg::CTRL_BIT]; // see (R12)
  assign datapath_reset_n      = st_ff.datapath_en[serdes_regs_pkg::CTRL_BIT]; // see (R15)

  offset_if ofs_bus ();

  assign ofs_bus.hold      = st_ff.offset_block[serdes_regs_pkg::CTRL_BIT]; // see (R13)
  assign ofs_bus.pending_a = offset_pending_a;
  assign ofs_bus.pending_b = offset_pending_b;
  assign offset_applied_a  = ofs_bus.applied_a;
  assign offset_applied_b  = ofs_bus.applied_b;

  offset_release u_offset_release (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .ofs     (ofs_bus.apply)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking reg_cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  phase_read_a: assert property (cfg_rd_en && cfg_addr == serdes_regs_pkg::PHASE_STATUS_OFS // see (R1)
      |=> cfg_rdata == ($past(phase_bin_sel) ^ ($past(phase_bin_sel) >> 1)))
    else $error("Phase read value wrong.");
  phase_gray_a: assert property ($past(phase_bin_sel) + 8'h01 == phase_bin_sel // see (R2)
      |-> $countones(phase_gray ^ $past(phase_gray)) == 1)
    else $error("Phase step changed more than one bit.");
  lock_live_a: assert property (cfg_rd_en && cfg_addr == serdes_regs_pkg::SYNTH_STATUS_OFS // see (R4)
      |=> cfg_rdata[7:4] == $past(synth_lock_live, 3))
    else $error("Lock field not live.");
  loss_set_a: assert property ($past(!synth_lock_live[0], 2) |=> st_ff.loss_sticky[0]) // see (R5)
    else $error("Loss bit zero not set.");
  loss_group_a: assert property (!st_ff.lock_sync[3] |=> st_ff.loss_sticky[3]) // see (R6)
    else $error("Loss bit three not set.");
  loss_keep_a: assert property (st_ff.loss_sticky[1] && !(wr_status && cfg_wdata[1]) // see (R7)
      |=> st_ff.loss_sticky[1])
    else $error("Sticky loss bit dropped.");
  loss_clear_a: assert property (wr_status && cfg_wdata[2] && st_ff.lock_sync[2] // see (R7)
      |=> !st_ff.loss_sticky[2])
    else $error("Loss bit not cleared.");
  link_hold_a: assert property (cfg_wr_en && cfg_addr == serdes_regs_pkg::LINK_RESET_OFS // see (R8)
      |=> link_reset_n == !$past(cfg_wdata[0]))
    else $error("Link hold not applied.");
  arrival_once_a: assert property (st_ff.arrival_done && !st_ff.link_reset[0] // see (R10)
      |=> $stable(lane_arrival_capture))
    else $error("Arrival values changed after capture.");
  vref_sel_a: assert property (cfg_wr_en && cfg_addr == serdes_regs_pkg::EXT_REF_OFS // see (R11)
      |=> external_vref_select == $past(cfg_wdata[0]))
    else $error("Reference select not applied.");
  cur_double_a: assert property (cfg_wr_en && cfg_addr == serdes_regs_pkg::CUR_DOUBLE_OFS // see (R12)
      |=> output_current_double == $past(cfg_wdata[0]))
    else $error("Current double not applied.");
  dp_run_a: assert property (cfg_wr_en && cfg_addr == serdes_regs_pkg::DATAPATH_EN_OFS // see (R15)
      |=> datapath_reset_n == $past(cfg_wdata[0]))
    else $error("Datapath run not applied.");
  reserved_rb_a: assert property (cfg_wr_en && cfg_addr == serdes_regs_pkg::OFFSET_BLOCK_OFS // see (R16)
      ##1 (cfg_rd_en && !cfg_wr_en && cfg_addr == serdes_regs_pkg::OFFSET_BLOCK_OFS)
      |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("Control register readback wrong.");

  loss_event_c: cover property (st_ff.loss_sticky[0] && st_ff.lock_sync[0]);
  arrival_cap_c: cover property ($rose(st_ff.arrival_done));
  phase_read_c: cover property (cfg_rd_en && cfg_addr == serdes_regs_pkg::PHASE_STATUS_OFS);

endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the link status and converter control register group.
// Assumes one clock domain and drives every input of the group directly.
`timescale 1ns/1ps
module testbench;
  // ****************************************************************
  // Stimulus and hookup
  // ****************************************************************
  logic         sys_clk;
  logic         reset_n;
  logic [9:0]   cfg_addr;
  logic         cfg_wr_en;
  logic         cfg_rd_en;
  logic [7:0]   cfg_wdata;
  logic [7:0]   cfg_rdata;
  logic [3:0]   lane_select;
  logic [127:0] lane_phase_bin;
  logic [3:0]   synth_lock_live;
  logic         eb_release_attempt;
  logic [127:0] lane_arrival_in;
  logic [127:0] lane_arrival_capture;
  logic         link_reset_n;
  logic         external_vref_select;
  logic         output_current_double;
  logic         datapath_reset_n;
  logic [15:0]  offset_pending_a;
  logic [15:0]  offset_pending_b;
  logic [15:0]  offset_applied_a;
  logic [15:0]  offset_applied_b;
  int           err_count;
  int           checked;

  serdes_status_dac_ctrl_regs uut (.sys_clk(sys_clk), .reset_n(reset_n), .cfg_addr(cfg_addr),
    .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .lane_select(lane_select), .lane_phase_bin(lane_phase_bin),
    .synth_lock_live(synth_lock_live), .eb_release_attempt(eb_release_attempt),
    .lane_arrival_in(lane_arrival_in), .lane_arrival_capture(lane_arrival_capture),
    .link_reset_n(link_reset_n), .external_vref_select(external_vref_select),
    .output_current_double(output_current_double), .datapath_reset_n(datapath_reset_n),
    .offset_pending_a(offset_pending_a), .offset_pending_b(offset_pending_b),
    .offset_applied_a(offset_applied_a), .offset_applied_b(offset_applied_b));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pins(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cfg_wr_en <= 1'b1;
    cfg_addr  <= a;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr_en <= 1'b0;
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    cfg_rd_en <= 1'b1;
    cfg_addr  <= a;
    @(posedge sys_clk);
    cfg_rd_en <= 1'b0;
    @(negedge sys_clk);
    chk_reg(cfg_rdata, exp);
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic done_msg(input string name);
    $display("test %s done, checks %0d mismatches %0d", name, checked, err_count);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  logic [9:0] ctrl_ofs [5];

  task automatic t_reset;
    foreach (ctrl_ofs[i]) rd_chk(ctrl_ofs[i], 8'h00);
    chk_reg({4'h0, link_reset_n, external_vref_select, output_current_double,
             datapath_reset_n}, 8'h08);
    done_msg("reset");
  endtask

  // Reserved bits are written with a mixed pattern so a dropped bit shows on readback.
  task automatic t_ctrl;
    foreach (ctrl_ofs[i]) wr(ctrl_ofs[i], 8'ha5);
    foreach (ctrl_ofs[i]) rd_chk(ctrl_ofs[i], 8'ha5);
    chk_reg({4'h0, link_reset_n, external_vref_select, output_current_double,
             datapath_reset_n}, 8'h07);
    foreach (ctrl_ofs[i]) wr(ctrl_ofs[i], 8'h5a);
    foreach (ctrl_ofs[i]) rd_chk(ctrl_ofs[i], 8'h5a);
    chk_reg({4'h0, link_reset_n, external_vref_select, output_current_double,
             datapath_reset_n}, 8'h08);
    done_msg("control");
  endtask

  // Phases stay still around each read, as a frozen recovery loop would keep them.
  task automatic t_phase;
    logic [7:0] b;
    for (int i = 0; i < 16; i += 5) begin
      @(posedge sys_clk);
      lane_select <= 4'(i);
      b = lane_phase_bin[8*i +: 8];
      rd_chk(serdes_regs_pkg::PHASE_STATUS_OFS, b ^ (b >> 1));
    end
    @(posedge sys_clk);
    lane_phase_bin[127:120] <= 8'h2f;
    rd_chk(serdes_regs_pkg::PHASE_STATUS_OFS, 8'h38);
    done_msg("phase");
  endtask

  task automatic t_synth;
    rd_chk(serdes_regs_pkg::SYNTH_STATUS_OFS, 8'hff);
    wr(serdes_regs_pkg::SYNTH_STATUS_OFS, 8'h0f);
    rd_chk(serdes_regs_pkg::SYNTH_STATUS_OFS, 8'hf0);
    @(posedge sys_clk);
    synth_lock_live <= 4'hb;
    wait_clk(4);
    rd_chk(serdes_regs_pkg::SYNTH_STATUS_OFS, 8'hb4);
    @(posedge sys_clk);
    synth_lock_live <= 4'hf;
    wait_clk(4);
    rd_chk(serdes_regs_pkg::SYNTH_STATUS_OFS, 8'hf4);
    wr(serdes_regs_pkg::SYNTH_STATUS_OFS, 8'hf0);
    rd_chk(serdes_regs_pkg::SYNTH_STATUS_OFS, 8'hf4);
    wr(serdes_regs_pkg::SYNTH_STATUS_OFS, 8'h04);
    rd_chk(serdes_regs_pkg::SYNTH_STATUS_OFS, 8'hf0);
    done_msg("synth");
  endtask

  // The release write keeps the reserved pattern so later readback still expects it.
  task automatic t_offset;
    int n;
    @(posedge sys_clk);
    offset_pending_a <= 16'h1234;
    offset_pending_b <= 16'habcd;
    wr(serdes_regs_pkg::OFFSET_BLOCK_OFS, 8'h01);
    wait_clk(2);
    offset_pending_a <= 16'h5555;
    offset_pending_b <= 16'h6666;
    wait_clk(3);
    @(negedge sys_clk);
    chk_pins(128'({offset_applied_a, offset_applied_b}), 128'h1234_abcd);
    wr(serdes_regs_pkg::OFFSET_BLOCK_OFS, 8'h5a);
    n = 0;
    while (offset_applied_a === 16'h1234 && n < 6) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 6) begin
      err_count++;
      print_verdict();
    end
    chk_pins(128'({offset_applied_a, offset_applied_b}), 128'h5555_6666);
    done_msg("offset");
  endtask

  // The link is held and then let go first, so the first attempt after that must capture.
  task automatic t_arrival;
    wr(serdes_regs_pkg::LINK_RESET_OFS, 8'h5b);
    @(negedge sys_clk);
    chk_reg({7'h00, link_reset_n}, 8'h00);
    wr(serdes_regs_pkg::LINK_RESET_OFS, 8'h5a);
    @(posedge sys_clk);
    lane_arrival_in    <= {16{8'h3c}};
    eb_release_attempt <= 1'b1;
    @(posedge sys_clk);
    eb_release_attempt <= 1'b0;
    @(negedge sys_clk);
    chk_pins(lane_arrival_capture, {16{8'h3c}});
    @(posedge sys_clk);
    lane_arrival_in    <= {16{8'hc3}};
    eb_release_attempt <= 1'b1;
    @(posedge sys_clk);
    eb_release_attempt <= 1'b0;
    wait_clk(2);
    @(negedge sys_clk);
    chk_pins(lane_arrival_capture, {16{8'h3c}});
    done_msg("arrival");
  endtask

  // The last write and read run back to back, with no idle cycle between them.
  task automatic t_unmapped;
    wr(10'h3ff, 8'hff);
    rd_chk(10'h3ff, 8'h00);
    foreach (ctrl_ofs[i]) rd_chk(ctrl_ofs[i], 8'h5a);
    @(posedge sys_clk);
    cfg_wr_en <= 1'b1;
    cfg_addr  <= serdes_regs_pkg::OFFSET_BLOCK_OFS;
    cfg_wdata <= 8'hfe;
    @(posedge sys_clk);
    cfg_wr_en <= 1'b0;
    cfg_rd_en <= 1'b1;
    @(posedge sys_clk);
    cfg_rd_en <= 1'b0;
    @(negedge sys_clk);
    chk_reg(cfg_rdata, 8'hfe);
    done_msg("unmapped");
  endtask

  initial begin
    ctrl_ofs = '{serdes_regs_pkg::LINK_RESET_OFS, serdes_regs_pkg::EXT_REF_OFS,
                 serdes_regs_pkg::CUR_DOUBLE_OFS, serdes_regs_pkg::OFFSET_BLOCK_OFS,
                 serdes_regs_pkg::DATAPATH_EN_OFS};
    err_count          = 0;
    checked            = 0;
    reset_n            = 1'b0;
    cfg_addr           = 10'h000;
    cfg_wr_en          = 1'b0;
    cfg_rd_en          = 1'b0;
    cfg_wdata          = 8'h00;
    lane_select        = 4'h0;
    synth_lock_live    = 4'hf;
    eb_release_attempt = 1'b0;
    lane_arrival_in    = 128'h0;
    offset_pending_a   = 16'h0000;
    offset_pending_b   = 16'h0000;
    for (int n = 0; n < 16; n++) lane_phase_bin[8*n +: 8] = 8'(n * 37 + 3);
    wait_clk(2);
    reset_n <= 1'b1;
    wait_clk(4);
    t_reset();
    t_ctrl();
    t_phase();
    t_synth();
    t_offset();
    t_arrival();
    t_unmapped();
    print_verdict();
  end
endmodule
